// *** core/mtd_dispatcher.sv ***
// Purpose: message driven task dispatch onto interchangeable threads
// Assumes: network and threads are logic on i_ref_clk
// Notes:   HOLD_DEPTH must be a power of two, at least two
`timescale 1ns/1ps
`default_nettype none
module mtd_dispatcher
    import mtd_pkg::*;
#(
    parameter int NUM_CORES  = MTD_NUM_CORES,
    parameter int THR_PER_CORE = MTD_THR_PER_CORE,
    parameter int HOLD_DEPTH = MTD_HOLD_DEPTH,
    parameter int NUM_CTX    = MTD_NUM_CTX,
    localparam int NT        = NUM_CORES * THR_PER_CORE,
    localparam int TW        = (NT > 1) ? $clog2(NT) : 1
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_rx_valid,
    input  wire mtd_msg_s          i_rx_msg,
    output logic                   o_rx_ready,
    input  wire logic [NT-1:0]     i_task_done,
    input  wire logic [NT-1:0]     i_tx_load,
    input  wire logic [NT-1:0]     i_send,
    input  wire logic [NT-1:0]     i_send_imm,
    input  wire mtd_msg_s [NT-1:0] i_tx_data,
    input  wire logic              i_tx_ready,
    output logic                   o_tx_valid,
    output mtd_msg_s               o_tx_msg,
    output logic [NT-1:0]          o_init_start,
    output logic [NT-1:0]          o_start,
    output mtd_msg_s [NT-1:0]      o_ext_regs,
    input  wire logic              i_ctx_req,
    input  wire logic [TW-1:0]     i_ctx_thread,
    input  wire logic [MTD_TOKEN_W-1:0] i_ctx_token,
    output logic                   o_ctx_grant,
    output logic                   o_ctx_deny
);

    localparam int PW = $clog2(HOLD_DEPTH);

    // ****************************************
    // thread slots
    // ****************************************
    logic [NT-1:0]     free;
    logic [NT-1:0]     held;
    logic [NT-1:0]     tx_pend;
    logic [NT-1:0]     disp;
    logic [NT-1:0]     tx_ack;
    mtd_msg_s [NT-1:0] tx_regs;
    mtd_msg_s          head;

    for (genvar g = 0; g < NT; g++) begin : g_thr
        mtd_thread_slot u_slot (
            .i_ref_clk    (i_ref_clk),
            .i_reset_n    (i_reset_n),
            .i_dispatch   (disp[g]),
            .i_msg        (head),
            .i_done       (i_task_done[g]),
            .i_tx_load    (i_tx_load[g]),
            .i_send       (i_send[g]),
            .i_send_imm   (i_send_imm[g]),
            .i_tx_data    (i_tx_data[g]),
            .i_tx_ack     (tx_ack[g]),
            .o_free       (free[g]),
            .o_init_start (o_init_start[g]),
            .o_start      (o_start[g]),
            .o_rx_regs    (o_ext_regs[g]),
            .o_ctx_held   (held[g]),
            .o_tx_pend    (tx_pend[g]),
            .o_tx_regs    (tx_regs[g])
        );
    end

    // ****************************************
    // hold queue, arrival order
    // ****************************************
    mtd_msg_s        hold_mem [HOLD_DEPTH];
    logic [PW-1:0]   wr_ptr_ff;
    logic [PW-1:0]   rd_ptr_ff;
    logic [PW:0]     cnt_ff;
    logic [PW:0]     nxt_cnt;
    logic            push;
    logic            pop;

    assign head = hold_mem[rd_ptr_ff];
    assign push = i_rx_valid && o_rx_ready;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            hold_mem[wr_ptr_ff] <= i_rx_msg;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr_ff  <= '0;
            rd_ptr_ff  <= '0;
            cnt_ff     <= '0;
            o_rx_ready <= 1'b0;
        end else begin
            wr_ptr_ff  <= wr_ptr_ff + PW'(push);
            rd_ptr_ff  <= rd_ptr_ff + PW'(pop);
            cnt_ff     <= nxt_cnt;
            o_rx_ready <= nxt_cnt < (PW+1)'(HOLD_DEPTH);
        end
    end

    // ****************************************
    // dispatch selection
    // ****************************************
    logic          found;
    logic [TW-1:0] sel;
    logic          tok_busy;
    logic          tok_range_ok;

    // the head waits while another task holds its token, so later
    // messages also wait: order is kept at the price of some stall
    always_comb begin
        found    = 1'b0;
        sel      = '0;
        tok_busy = 1'b0;
        for (int i = 0; i < NT; i++) begin
            if (free[i] && !found) begin
                found = 1'b1;
                sel   = TW'(i);
            end
            if (held[i] && o_ext_regs[i].ctx_token == head.ctx_token) begin
                tok_busy = 1'b1;
            end
        end
    end

    assign tok_range_ok = int'(head.ctx_token) < NUM_CTX;
    assign pop = (cnt_ff != '0) && found &&
                 !(head.has_ctx && (tok_busy || !tok_range_ok));

    always_comb begin
        disp = '0;
        disp[sel] = pop;
    end

    // ****************************************
    // transmit arbitration
    // ****************************************
    logic          tx_found;
    logic [TW-1:0] tsel;
    logic          tx_go;

    always_comb begin
        tx_found = 1'b0;
        tsel     = '0;
        for (int i = 0; i < NT; i++) begin
            if (tx_pend[i] && !tx_found) begin
                tx_found = 1'b1;
                tsel     = TW'(i);
            end
        end
    end

    assign tx_go = tx_found && (!o_tx_valid || i_tx_ready);

    always_comb begin
        tx_ack = '0;
        tx_ack[tsel] = tx_go;
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tx_valid <= 1'b0;
            o_tx_msg   <= MTD_MSG_RST;
        end else if (tx_go) begin
            o_tx_valid <= 1'b1;
            o_tx_msg   <= tx_regs[tsel];
        end else if (i_tx_ready) begin
            o_tx_valid <= 1'b0;
        end
    end

    // ****************************************
    // context access check
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ctx_grant <= 1'b0;
            o_ctx_deny  <= 1'b0;
        end else begin
            o_ctx_grant <= i_ctx_req && held[i_ctx_thread] &&
                o_ext_regs[i_ctx_thread].ctx_token == i_ctx_token;
            o_ctx_deny  <= i_ctx_req && !(held[i_ctx_thread] &&
                o_ext_regs[i_ctx_thread].ctx_token == i_ctx_token);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_ready_to_go;
        cnt_ff != '0 && found && !head.has_ctx;
    endsequence

    sequence s_started;
        o_start != '0;
    endsequence

    a_msg_starts_task: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        s_ready_to_go |=> s_started)
        else $error("waiting message not dispatched to a free thread");

    a_only_free_thr: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        pop |-> free[sel])
        else $error("dispatch onto a busy thread");

    a_hold_when_busy: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        push && free == '0 |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("message lost while all threads busy");

    a_fifo_order: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        pop |=> rd_ptr_ff == $past(rd_ptr_ff) + 1'b1)
        else $error("held messages left out of order");

    a_full_refuses: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        cnt_ff == (PW+1)'(HOLD_DEPTH) |-> !o_rx_ready)
        else $error("ready raised while hold queue full");

    // two holders of one token, judged across the slots, not by the gate
    logic dup_tok;

    always_comb begin
        dup_tok = 1'b0;
        for (int i = 0; i < NT; i++) begin
            for (int j = i + 1; j < NT; j++) begin
                if (held[i] && held[j] &&
                    o_ext_regs[i].ctx_token == o_ext_regs[j].ctx_token) begin
                    dup_tok = 1'b1;
                end
            end
        end
    end

    a_token_excl: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !dup_tok)
        else $error("token held by two tasks at once");

    a_ctx_answer: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        i_ctx_req |=> o_ctx_grant != o_ctx_deny)
        else $error("context request got no single answer");

    a_send_out: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        tx_go |=> o_tx_valid && o_tx_msg == $past(tx_regs[tsel]))
        else $error("sent message not presented");

    a_tx_stable: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_msg))
        else $error("outgoing message dropped under back-pressure");

endmodule
`default_nettype wire

// *** core/mtd_pkg.sv ***
// Purpose: shared types and constants of the message task dispatcher
// Assumes: one processor clock, messages arrive from logic on that clock
// Notes:   message layout widths are fixed here for every file
package mtd_pkg;

    // ****************************************
    // message layout
    // ****************************************
    localparam int MTD_DEST_W  = 4;
    localparam int MTD_TASK_W  = 8;
    localparam int MTD_TOKEN_W = 6;
    localparam int MTD_ARG_W   = 32;
    localparam int MTD_NARGS   = 2;

    // ****************************************
    // default sizes
    // ****************************************
    localparam int MTD_NUM_CORES   = 1;
    localparam int MTD_THR_PER_CORE = 4;
    localparam int MTD_HOLD_DEPTH  = 4;
    localparam int MTD_NUM_CTX     = 64;

    typedef struct packed {
        logic [MTD_DEST_W-1:0]          dest;
        logic [MTD_TASK_W-1:0]          task_id;
        logic                           has_ctx;
        logic [MTD_TOKEN_W-1:0]         ctx_token;
        logic [MTD_NARGS*MTD_ARG_W-1:0] args;
    } mtd_msg_s;

    localparam mtd_msg_s MTD_MSG_RST = '0;

    // gray along boot -> init -> idle -> task -> idle
    typedef enum logic [1:0] {
        MTD_BOOT = 2'h0,
        MTD_INIT = 2'h1,
        MTD_IDLE = 2'h3,
        MTD_TASK = 2'h2
    } mtd_thr_state_e;

    localparam mtd_thr_state_e MTD_THR_RST = MTD_BOOT;

endpackage

// *** core/mtd_thread_slot.sv ***
// Purpose: one hardware thread: life cycle, receive and transmit registers
// Assumes: the dispatcher offers a message only while o_free is high
// Notes:   a started task is never stopped by this slot
`timescale 1ns/1ps
`default_nettype none
module mtd_thread_slot
    import mtd_pkg::*;
(
    input  wire logic     i_ref_clk,
    input  wire logic     i_reset_n,
    input  wire logic     i_dispatch,
    input  wire mtd_msg_s i_msg,
    input  wire logic     i_done,
    input  wire logic     i_tx_load,
    input  wire logic     i_send,
    input  wire logic     i_send_imm,
    input  wire mtd_msg_s i_tx_data,
    input  wire logic     i_tx_ack,
    output logic          o_free,
    output logic          o_init_start,
    output logic          o_start,
    output mtd_msg_s      o_rx_regs,
    output logic          o_ctx_held,
    output logic          o_tx_pend,
    output mtd_msg_s      o_tx_regs
);

    mtd_thr_state_e state_ff;
    mtd_thr_state_e nxt_state;

    // ****************************************
    // thread life cycle
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MTD_BOOT: nxt_state = MTD_INIT;
            MTD_INIT: if (i_done) nxt_state = MTD_IDLE;
            MTD_IDLE: if (i_dispatch) nxt_state = MTD_TASK;
            MTD_TASK: if (i_done) nxt_state = MTD_IDLE;
            default:  nxt_state = MTD_BOOT;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff     <= MTD_THR_RST;
            o_free       <= 1'b0;
            o_init_start <= 1'b0;
            o_start      <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            o_free       <= (nxt_state == MTD_IDLE);
            o_init_start <= (state_ff == MTD_BOOT);
            o_start      <= (state_ff == MTD_IDLE) && i_dispatch;
        end
    end

    // ****************************************
    // receive registers and token ownership
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rx_regs  <= MTD_MSG_RST;
            o_ctx_held <= 1'b0;
        end else if (i_dispatch && state_ff == MTD_IDLE) begin
            o_rx_regs  <= i_msg;
            o_ctx_held <= i_msg.has_ctx;
        end else if (i_done) begin
            o_ctx_held <= 1'b0;
        end else if (i_tx_ack && o_tx_regs.has_ctx &&
                     o_tx_regs.ctx_token == o_rx_regs.ctx_token) begin
            // token travels on with the message
            o_ctx_held <= 1'b0;
        end
    end

    // ****************************************
    // transmit registers
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tx_regs <= MTD_MSG_RST;
            o_tx_pend <= 1'b0;
        end else begin
            if ((i_tx_load || i_send_imm) && !o_tx_pend) begin
                o_tx_regs <= i_tx_data;
            end
            if (i_send || i_send_imm) begin
                o_tx_pend <= 1'b1;
            end else if (i_tx_ack) begin
                o_tx_pend <= 1'b0;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_took_msg;
        i_dispatch && state_ff == MTD_IDLE;
    endsequence

    a_args_preloaded: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        s_took_msg |=> o_start && o_rx_regs == $past(i_msg))
        else $error("task started without its arguments");

    a_no_preempt: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        state_ff == MTD_TASK && !i_done |=> state_ff == MTD_TASK)
        else $error("running task left its thread early");

    a_init_once: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        state_ff inside {MTD_IDLE, MTD_TASK} |=> state_ff != MTD_INIT)
        else $error("init routine entered twice");

endmodule
`default_nettype wire

// *** sim/message_task_dispatcher_tb.sv ***
// Purpose: self-checking bench of the message task dispatcher
// Assumes: two cores of two threads, tokens above 47 are out of range
// Notes:   transmit order is compared as a set, lowest thread goes first
`timescale 1ns/1ps
`default_nettype none
module message_task_dispatcher_tb;
    import mtd_pkg::*;
    localparam int NT = 4;
    logic              i_ref_clk, i_reset_n, stall, ctx_req, grant, deny;
    logic              rx_valid, rx_ready, tx_valid, tx_ready;
    mtd_msg_s          rx_msg, tx_msg;
    logic [NT-1:0]     done, load, snd, snd_imm, init_start, start, busy;
    mtd_msg_s [NT-1:0] tx_data, ext_regs;
    logic [1:0]        ctx_thr;
    logic [5:0]        ctx_tok;
    mtd_msg_s          exp_q[$];
    mtd_msg_s          tx_exp[$];
    int                num_errors, checked, n, k;
    bit                init_seen;
    mtd_msg_s          exp_m;
    int                order [4] = '{2, 0, 3, 1};

    mtd_dispatcher #(.NUM_CORES(2), .THR_PER_CORE(2), .HOLD_DEPTH(4),
        .NUM_CTX(48)) dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_rx_valid(rx_valid), .i_rx_msg(rx_msg), .o_rx_ready(rx_ready),
        .i_task_done(done), .i_tx_load(load), .i_send(snd),
        .i_send_imm(snd_imm), .i_tx_data(tx_data), .i_tx_ready(tx_ready),
        .o_tx_valid(tx_valid), .o_tx_msg(tx_msg),
        .o_init_start(init_start), .o_start(start), .o_ext_regs(ext_regs),
        .i_ctx_req(ctx_req), .i_ctx_thread(ctx_thr), .i_ctx_token(ctx_tok),
        .o_ctx_grant(grant), .o_ctx_deny(deny));

    mtd_net_model net (.i_clk(i_ref_clk), .i_stall(stall),
        .i_rx_ready(rx_ready), .o_rx_valid(rx_valid), .o_rx_msg(rx_msg),
        .i_tx_valid(tx_valid), .i_tx_msg(tx_msg), .o_tx_ready(tx_ready));

    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string name, input logic [95:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic mtd_msg_s rnd_msg(input int tok);
        logic [95:0] r;
        mtd_msg_s    m;
        r = {$urandom, $urandom, $urandom};
        m = r[$bits(mtd_msg_s)-1:0];
        m.has_ctx = (tok >= 0);
        m.ctx_token = tok[5:0];
        return m;
    endfunction

    function automatic int low_free();
        for (int i = 0; i < NT; i++) begin
            if (!busy[i]) return i;
        end
        return -1;
    endfunction

    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask

    task automatic push(input mtd_msg_s m);
        net.push(m);
        exp_q.push_back(m);
    endtask

    task automatic send(input int t, input logic imm, input mtd_msg_s m);
        tx_exp.push_back(m);
        tick();
        tx_data[t] = m;
        if (!imm) begin
            load[t] = 1'b1;
            tick();
            load[t] = 1'b0;
        end
        snd[t] = !imm;
        snd_imm[t] = imm;
        tick();
        snd[t] = 1'b0;
        snd_imm[t] = 1'b0;
        tx_data[t] = ~m;
    endtask

    task automatic finish(input int t);
        send(t, t[0], rnd_msg(-1));
        tick();
        done[t] = 1'b1;
        tick();
        done[t] = 1'b0;
        busy[t] = 1'b0;
    endtask

    task automatic req(input int t, input int tok, input logic [1:0] exp);
        logic [1:0] gd;
        tick();
        ctx_req = 1'b1;
        ctx_thr = t[1:0];
        ctx_tok = tok[5:0];
        tick();
        ctx_req = 1'b0;
        @(negedge i_ref_clk);
        gd = {grant, deny};
        @(negedge i_ref_clk);
        gd = gd | {grant, deny};
        check("ctx_answer", gd, exp);
    endtask

    task automatic drain();
        stall = 1'b0;
        k = 0;
        while (net.got_q.size() != tx_exp.size() && k < 200) begin
            tick();
            k++;
        end
    endtask

    always @(negedge i_ref_clk) begin
        if (i_reset_n === 1'b1) begin
            if (init_seen) check("init_again", init_start, '0);
            for (int t = 0; t < NT; t++) begin
                if (start[t] === 1'b1) begin
                    check("start_thread", t, low_free());
                    exp_m = exp_q.pop_front();
                    check("ext_regs", ext_regs[t], exp_m);
                    busy[t] = 1'b1;
                end
            end
        end
    end

    initial begin
        repeat (5000) @(posedge i_ref_clk);
        num_errors++;
        test_done();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(71));
        {i_reset_n, stall, ctx_req, done, load, snd, snd_imm} = '0;
        {ctx_thr, ctx_tok, init_seen} = '0;
        tx_data = '0;
        busy = '1;
        repeat (3) @(posedge i_ref_clk);
        check("ready_in_reset", {rx_ready, tx_valid, start}, '0);
        #1;
        i_reset_n = 1'b1;
        push(rnd_msg(-1));
        n = 0;
        repeat (4) begin
            @(negedge i_ref_clk);
            n += $countones(init_start);
        end
        check("init_pulses", n, NT);
        tick();
        done = '1;
        tick();
        done = '0;
        busy = '0;
        init_seen = 1'b1;
        for (int i = 0; i < 8; i++) push(rnd_msg(-1));
        repeat (14) tick();
        check("queue_full", rx_ready, 1'b0);
        check("held_count", exp_q.size(), 5);
        stall = 1'b1;
        foreach (order[i]) finish(order[i]);
        // last release dispatches one edge later, seen at the next negedge
        repeat (2) tick();
        check("tx_stands", tx_valid, 1'b1);
        check("held_left", exp_q.size(), 1);
        drain();
        for (int t = 0; t < NT; t++) finish(t);
        drain();
        push(rnd_msg(5));
        repeat (6) tick();
        req(1, 5, 2'b10);
        req(0, 5, 2'b01);
        req(1, 6, 2'b01);
        push(rnd_msg(5));
        repeat (8) tick();
        check("token_blocks", exp_q.size(), 1);
        send(1, 1'b1, rnd_msg(5));
        drain();
        repeat (6) tick();
        check("token_moved", exp_q.size(), 0);
        req(2, 5, 2'b10);
        req(1, 5, 2'b01);
        for (int t = 0; t < 3; t++) finish(t);
        push(rnd_msg(50));
        repeat (8) tick();
        check("token_range", exp_q.size(), 1);
        drain();
        check("tx_count", net.got_q.size(), tx_exp.size());
        foreach (net.got_q[i]) begin
            k = -1;
            foreach (tx_exp[j]) begin
                if (k < 0 && tx_exp[j] === net.got_q[i]) begin
                    k = j;
                end
            end
            check("tx_msg", k >= 0, 1'b1);
            if (k >= 0) tx_exp.delete(k);
        end
        test_done();
    end
endmodule
`default_nettype wire

// *** sim/mtd_net_model.sv ***
// Purpose: messaging network model on the far side of the dispatcher
// Assumes: the bench calls push and drives i_stall
// Notes:   an idle message bus shows a changing pattern, not stale data
`timescale 1ns/1ps
`default_nettype none
module mtd_net_model
    import mtd_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_stall,
    input  wire logic     i_rx_ready,
    output logic          o_rx_valid,
    output mtd_msg_s      o_rx_msg,
    input  wire logic     i_tx_valid,
    input  wire mtd_msg_s i_tx_msg,
    output logic          o_tx_ready
);
    mtd_msg_s src_q[$];
    mtd_msg_s got_q[$];
    logic     took;

    task automatic push(input mtd_msg_s m);
        src_q.push_back(m);
    endtask

    assign o_tx_ready = !i_stall;

    initial begin
        o_rx_valid = 1'b0;
        o_rx_msg   = MTD_MSG_RST;
        forever begin
            @(posedge i_clk);
            took = o_rx_valid && i_rx_ready;
            if (i_tx_valid && o_tx_ready) begin
                got_q.push_back(i_tx_msg);
            end
            #1;
            if (took) begin
                void'(src_q.pop_front());
            end
            if (src_q.size() == 0) begin
                o_rx_valid = 1'b0;
                o_rx_msg   = ~o_rx_msg;
            end else begin
                o_rx_valid = 1'b1;
                o_rx_msg   = src_q[0];
            end
        end
    end
endmodule
`default_nettype wire
